//--- hdl/receiver_mode_sequencer.sv
`timescale 1ns/1ps
`include "rms_cfg.svh"
module receiver_mode_sequencer
(
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic [2:0]                 mode_field,
  input  wire logic                       listen_enable,
  input  wire logic                       sequencer_disable,
  input  wire logic                       ook_mode,
  input  wire logic                       bit_sync_enable,
  input  wire logic [15:0]                bit_period_cycles,
  input  wire logic [15:0]                receive_bandwidth_cycles,
  input  wire logic [15:0]                crystal_wake_time,
  input  wire logic [15:0]                synth_wake_time,
  input  wire logic                       pll_lock_raw,
  input  wire logic                       rssi_raw,
  input  wire logic                       sync_word_hit,
  input  wire logic                       payload_complete_irq,
  input  wire logic [7:0]                 rx_start_timeout_count,
  input  wire logic                       listen_accept_rule,
  input  wire logic [1:0]                 listen_end_action,
  input  wire rms_pkg::listen_window_t    rx_window,
  input  wire rms_pkg::listen_window_t    idle_window,
  input  wire logic                       rc_calibration_start,
  input  wire rms_pkg::auto_cfg_t         auto_cfg,
  input  wire logic                       auto_enter_trigger,
  input  wire logic                       auto_exit_trigger,
  output logic [2:0]                      active_mode,
  output logic                            crystal_on,
  output logic                            synth_on,
  output logic                            receiver_on,
  output logic                            pll_lock_out,
  output logic                            receiver_ready_irq,
  output logic                            data_valid,
  output logic                            signal_level_threshold,
  output logic                            timeout_irq,
  output logic                            buffer_flush,
  output logic                            rc_calibration_done,
  output logic                            listen_stopped
);

  // Two-flop synchronisers for asynchronous analog status
  logic [1:0] lock_sync_reg;
  logic [1:0] rssi_sync_reg;
  logic       pll_locked;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_sync_reg <= 2'h0;
      rssi_sync_reg <= 2'h0;
    end
    else
    begin
      lock_sync_reg <= {lock_sync_reg[0], pll_lock_raw};
      rssi_sync_reg <= {rssi_sync_reg[0], rssi_raw};
    end
  end
  assign pll_locked             = lock_sync_reg[1];
  assign pll_lock_out           = pll_locked;
  assign signal_level_threshold = rssi_sync_reg[1];

  // RC tick enable: listen timing runs only on this pulse
  logic [7:0] rc_div_reg;
  logic       rc_tick;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rc_div_reg <= 8'h00;
    else if (rc_div_reg == 8'(`RC_DIV_CYC - 1))
      rc_div_reg <= 8'h00;
    else
      rc_div_reg <= rc_div_reg + 8'h01;
  end
  assign rc_tick = (rc_div_reg == 8'h00);

  // Window length in RC ticks
  function automatic logic [27:0] window_ticks(input rms_pkg::listen_window_t w);
    logic [19:0] res;
    res = 20'h00000;
    if (w.resolution == `RES_64US)
      res = 20'(`RES_64US_TICKS);
    else if (w.resolution == `RES_4MS)
      res = 20'(`RES_4MS_TICKS);
    else if (w.resolution == `RES_262MS)
      res = 20'(`RES_262MS_TICKS);
    window_ticks = 28'(res) * 28'(w.coefficient);
  endfunction

  // Mode decode of the mode field
  function automatic rms_pkg::op_state_t decode_mode(input logic [2:0] m);
    if (m == `MODE_STANDBY)
      decode_mode = rms_pkg::ST_STANDBY;
    else if (m == `MODE_SYNTH)
      decode_mode = rms_pkg::ST_SYNTH;
    else if (m == `MODE_RECEIVE)
      decode_mode = rms_pkg::ST_RECEIVE;
    else
      decode_mode = rms_pkg::ST_SLEEP;
  endfunction

  // Listen controller state
  rms_pkg::listen_state_t ls_reg;
  logic [27:0]            ls_cnt_reg;
  logic                   listen_want_rx;
  logic                   wanted;
  logic                   rx_ready_lvl;
  logic                   packet_end;
  assign wanted     = signal_level_threshold &&
                      (!listen_accept_rule || sync_word_hit);
  assign packet_end = payload_complete_irq || timeout_irq;

  // Auto-mode middle state tracking
  logic in_middle_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      in_middle_reg <= 1'b0;
    else if (!(auto_cfg.enter_trigger_en && auto_cfg.exit_trigger_en) || listen_enable)
      in_middle_reg <= 1'b0;
    else if (!in_middle_reg && auto_enter_trigger)
      in_middle_reg <= 1'b1;
    else if (in_middle_reg && auto_exit_trigger)
      in_middle_reg <= 1'b0;
  end

  // Requested target from listen, auto-mode or mode field
  rms_pkg::op_state_t target;
  always_comb
  begin
    if (listen_enable && ls_reg != rms_pkg::LS_DONE)
      target = listen_want_rx ? rms_pkg::ST_RECEIVE : rms_pkg::ST_SLEEP;
    else if (listen_enable && listen_end_action == `END_STAY)
      target = rms_pkg::ST_RECEIVE;
    else if (in_middle_reg)
      target = decode_mode(auto_cfg.middle_mode);
    else
      target = decode_mode(mode_field);
  end

  // Mode sequencer with wake timers
  rms_pkg::op_state_t op_reg;
  logic [15:0]        seq_cnt_reg;
  logic [15:0]        rx_start_cyc;
  logic [15:0]        cf_cyc;
  // Filter settle: 21 or 34 over 4*BW, BW given as cycles per Hz unit
  assign cf_cyc = 16'(((ook_mode ? `CF_OOK_NUM : `CF_FSK_NUM) *
                       receive_bandwidth_cycles) >> 2);
  // Trade-off: worst-case budget, one RSSI and one AFC/relock stage
  assign rx_start_cyc = 16'(`FRONT_END_CYC) + cf_cyc
                      + 16'(`AFC_SAMPLE_BITS * bit_period_cycles)
                      + 16'(`PLL_RELOCK_CYC)
                      + 16'(`RSSI_SAMPLE_MULT * (receive_bandwidth_cycles >> 2));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_reg      <= rms_pkg::ST_SLEEP;
      seq_cnt_reg <= 16'h0000;
    end
    else if (sequencer_disable)
    begin
      op_reg      <= target;
      seq_cnt_reg <= 16'h0000;
    end
    else
    begin
      // Saturate so a long stay never wraps into a fresh wake wait
      if (seq_cnt_reg != 16'hFFFF)
        seq_cnt_reg <= seq_cnt_reg + 16'h0001;
      case (op_reg)
        rms_pkg::ST_SLEEP:
          if (target != rms_pkg::ST_SLEEP)
          begin
            op_reg      <= rms_pkg::ST_STANDBY;
            seq_cnt_reg <= 16'h0000;
          end
        rms_pkg::ST_STANDBY:
          if (target == rms_pkg::ST_SLEEP)
            op_reg <= rms_pkg::ST_SLEEP;
          else if (target != rms_pkg::ST_STANDBY && seq_cnt_reg >= crystal_wake_time)
          begin
            op_reg      <= rms_pkg::ST_SYNTH;
            seq_cnt_reg <= 16'h0000;
          end
        rms_pkg::ST_SYNTH:
          if (target == rms_pkg::ST_SLEEP || target == rms_pkg::ST_STANDBY)
            op_reg <= target;
          else if (target == rms_pkg::ST_RECEIVE && pll_locked &&
                   seq_cnt_reg >= synth_wake_time)
          begin
            op_reg      <= rms_pkg::ST_RX_START;
            seq_cnt_reg <= 16'h0000;
          end
        rms_pkg::ST_RX_START:
          if (target != rms_pkg::ST_RECEIVE)
            op_reg <= (target == rms_pkg::ST_SLEEP) ? rms_pkg::ST_SLEEP : rms_pkg::ST_SYNTH;
          else if (seq_cnt_reg >= rx_start_cyc)
            op_reg <= rms_pkg::ST_RECEIVE;
        rms_pkg::ST_RECEIVE:
          if (target != rms_pkg::ST_RECEIVE)
          begin
            op_reg      <= (target == rms_pkg::ST_SYNTH) ? rms_pkg::ST_SYNTH : target;
            seq_cnt_reg <= 16'h0000;
          end
        default:
          op_reg <= rms_pkg::ST_SLEEP;
      endcase
    end
  end

  // Block enables and reported mode from flip-flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      crystal_on  <= 1'b0;
      synth_on    <= 1'b0;
      receiver_on <= 1'b0;
      active_mode <= `MODE_SLEEP;
    end
    else
    begin
      crystal_on  <= (op_reg != rms_pkg::ST_SLEEP);
      synth_on    <= (op_reg == rms_pkg::ST_SYNTH) || (op_reg == rms_pkg::ST_RX_START) ||
                     (op_reg == rms_pkg::ST_RECEIVE);
      receiver_on <= (op_reg == rms_pkg::ST_RX_START) || (op_reg == rms_pkg::ST_RECEIVE);
      case (op_reg)
        rms_pkg::ST_STANDBY: active_mode <= `MODE_STANDBY;
        rms_pkg::ST_SYNTH:   active_mode <= `MODE_SYNTH;
        rms_pkg::ST_RX_START,
        rms_pkg::ST_RECEIVE: active_mode <= `MODE_RECEIVE;
        default:             active_mode <= `MODE_SLEEP;
      endcase
    end
  end
  assign rx_ready_lvl = (op_reg == rms_pkg::ST_RECEIVE);

  // Ready pulse on entry to receive, then preamble bit count
  logic        ready_d_reg;
  logic [15:0] bit_cnt_reg;
  logic [3:0]  pre_bits_reg;
  logic [10:0] bits8_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ready_d_reg        <= 1'b0;
      receiver_ready_irq <= 1'b0;
      bit_cnt_reg        <= 16'h0000;
      pre_bits_reg       <= 4'h0;
      bits8_reg          <= 11'h000;
      data_valid         <= 1'b0;
      timeout_irq        <= 1'b0;
    end
    else
    begin
      ready_d_reg        <= rx_ready_lvl;
      receiver_ready_irq <= rx_ready_lvl && !ready_d_reg;
      timeout_irq        <= 1'b0;
      if (!rx_ready_lvl)
      begin
        bit_cnt_reg  <= 16'h0000;
        pre_bits_reg <= 4'h0;
        bits8_reg    <= 11'h000;
        data_valid   <= 1'b0;
      end
      else
      begin
        if (!bit_sync_enable)
          data_valid <= 1'b1;
        else if (pre_bits_reg >= 4'(`PREAMBLE_BITS))
          data_valid <= 1'b1;
        if (bit_cnt_reg + 16'h0001 >= bit_period_cycles)
        begin
          bit_cnt_reg <= 16'h0000;
          if (pre_bits_reg < 4'(`PREAMBLE_BITS))
            pre_bits_reg <= pre_bits_reg + 4'h1;
          if (!signal_level_threshold && rx_start_timeout_count != 8'h00)
          begin
            bits8_reg <= bits8_reg + 11'h001;
            if (bits8_reg + 11'h001 ==
                11'(rx_start_timeout_count * `TIMEOUT_BIT_MULT))
              timeout_irq <= 1'b1;
          end
        end
        else
          bit_cnt_reg <= bit_cnt_reg + 16'h0001;
      end
    end
  end

  // Listen cycling: idle and receive windows on RC ticks
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ls_reg       <= rms_pkg::LS_OFF;
      ls_cnt_reg   <= 28'h0000000;
      buffer_flush <= 1'b0;
    end
    else
    begin
      buffer_flush <= 1'b0;
      if (!listen_enable)
        ls_reg <= rms_pkg::LS_OFF;
      else
        case (ls_reg)
          rms_pkg::LS_OFF:
          begin
            ls_reg     <= rms_pkg::LS_IDLE;
            ls_cnt_reg <= 28'h0000000;
          end
          rms_pkg::LS_IDLE:
            if (rc_tick)
            begin
              if (ls_cnt_reg + 28'h0000001 >= window_ticks(idle_window))
              begin
                ls_reg       <= rms_pkg::LS_RX;
                ls_cnt_reg   <= 28'h0000000;
                buffer_flush <= 1'b1;
              end
              else
                ls_cnt_reg <= ls_cnt_reg + 28'h0000001;
            end
          rms_pkg::LS_RX:
            if (rx_ready_lvl && wanted)
              ls_reg <= (listen_end_action == `END_STAY) ? rms_pkg::LS_DONE
                                                         : rms_pkg::LS_HOLD;
            else if (rc_tick)
            begin
              // Window counts from wake, so startup eats into it
              if (ls_cnt_reg + 28'h0000001 >= window_ticks(rx_window))
              begin
                ls_reg     <= rms_pkg::LS_IDLE;
                ls_cnt_reg <= 28'h0000000;
              end
              else
                ls_cnt_reg <= ls_cnt_reg + 28'h0000001;
            end
          rms_pkg::LS_HOLD:
            if (packet_end)
            begin
              ls_cnt_reg <= 28'h0000000;
              ls_reg     <= (listen_end_action == `END_RESUME) ? rms_pkg::LS_IDLE
                                                               : rms_pkg::LS_DONE;
            end
          default:
            ls_reg <= rms_pkg::LS_DONE;
        endcase
    end
  end
  assign listen_want_rx = (ls_reg == rms_pkg::LS_RX) || (ls_reg == rms_pkg::LS_HOLD);
  assign listen_stopped = (ls_reg == rms_pkg::LS_DONE);

  // RC calibration: runs after reset and on request; set wins over clear
  logic       cal_req_d_reg;
  logic       cal_busy_reg;
  logic [7:0] cal_cnt_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cal_req_d_reg       <= 1'b0;
      cal_busy_reg        <= 1'b1;
      cal_cnt_reg         <= 8'h00;
      rc_calibration_done <= 1'b0;
    end
    else
    begin
      cal_req_d_reg <= rc_calibration_start;
      if (cal_busy_reg)
      begin
        cal_cnt_reg <= cal_cnt_reg + 8'h01;
        if (cal_cnt_reg == 8'hFF)
        begin
          cal_busy_reg        <= 1'b0;
          rc_calibration_done <= 1'b1;
        end
      end
      else if (rc_calibration_start && !cal_req_d_reg)
      begin
        cal_busy_reg        <= 1'b1;
        cal_cnt_reg         <= 8'h00;
        rc_calibration_done <= 1'b0;
      end
    end
  end

endmodule

//--- hdl/rms_cfg.svh
`ifndef RMS_CFG_SVH
`define RMS_CFG_SVH

// Operating mode field codes
`define MODE_SLEEP        3'h0
`define MODE_STANDBY      3'h1
`define MODE_SYNTH        3'h2
`define MODE_RECEIVE      3'h4

// Listen window resolution codes
`define RES_64US          2'h1
`define RES_4MS           2'h2
`define RES_262MS         2'h3

// End-of-cycle action codes
`define END_STAY          2'h0
`define END_TO_MODE       2'h1
`define END_RESUME        2'h2

// Clock rate and printed times
`define CLK_MHZ           100
`define FRONT_END_US      20
`define PLL_BW_KHZ        300
`define PLL_RELOCK_NUM    5
`define CF_FSK_NUM        21
`define CF_OOK_NUM        34
`define AFC_SAMPLE_BITS   4
`define RSSI_SAMPLE_MULT  2
`define PREAMBLE_BITS     12
`define TIMEOUT_BIT_MULT  8

// Derived cycle counts (longest times round down)
`define FRONT_END_CYC     (`FRONT_END_US * `CLK_MHZ)
`define PLL_RELOCK_CYC    ((`PLL_RELOCK_NUM * `CLK_MHZ * 1000) / `PLL_BW_KHZ)

// Listen resolutions in RC ticks (RC tick taken as 1 us enable)
`define RC_DIV_CYC        `CLK_MHZ
`define RES_64US_TICKS    64
`define RES_4MS_TICKS     4100
`define RES_262MS_TICKS   262000

`endif

//--- hdl/rms_pkg.sv
package rms_pkg;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_STANDBY,
    ST_SYNTH,
    ST_RX_START,
    ST_RECEIVE
  } op_state_t;

  typedef enum logic [2:0] {
    LS_OFF,
    LS_IDLE,
    LS_RX,
    LS_HOLD,
    LS_DONE
  } listen_state_t;

  typedef struct packed {
    logic [1:0] resolution;
    logic [7:0] coefficient;
  } listen_window_t;

  typedef struct packed {
    logic [2:0] middle_mode;
    logic       enter_trigger_en;
    logic       exit_trigger_en;
  } auto_cfg_t;

endpackage

//--- sim/front_end_model.sv
`timescale 1ns/1ps
// Synthesizer loop stand-in: lock a fixed time after power-up
module front_end_model
#(
  parameter int LOCK_CYC = 30
)
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic synth_on,
  output logic      pll_lock_raw
);
  int on_cnt;

  // Lock drops at once when off, so a stale lock never fools the sequencer
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      on_cnt <= 0;
    else if (!synth_on)
      on_cnt <= 0;
    else if (on_cnt < LOCK_CYC)
      on_cnt <= on_cnt + 1;

  assign pll_lock_raw = (on_cnt == LOCK_CYC);
endmodule

//--- sim/receiver_mode_sequencer_chk.sv
`timescale 1ns/1ps
module receiver_mode_sequencer_chk
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [2:0]  mode_field,
  input wire logic        listen_enable,
  input wire logic        sequencer_disable,
  input wire logic        bit_sync_enable,
  input wire logic [15:0] bit_period_cycles,
  input wire logic        pll_lock_raw,
  input wire logic [7:0]  rx_start_timeout_count,
  input wire logic        rc_calibration_start,
  input wire logic [2:0]  active_mode,
  input wire logic        synth_on,
  input wire logic        receiver_on,
  input wire logic        pll_lock_out,
  input wire logic        receiver_ready_irq,
  input wire logic        data_valid,
  input wire logic        timeout_irq,
  input wire logic        buffer_flush,
  input wire logic        rc_calibration_done,
  input wire logic        listen_stopped
);
  int since_rel;
  int since_rdy;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Synchronisers still hold reset zeros just after release
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      since_rel <= 0;
    else if (since_rel < 4)
      since_rel <= since_rel + 1;

  // Cycles since the last ready pulse; starts as long ago
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      since_rdy <= 1000000;
    else if (receiver_ready_irq)
      since_rdy <= 1;
    else if (since_rdy < 1000000)
      since_rdy <= since_rdy + 1;

  // Mode field held with the sequencer bypassed
  sequence direct_hold(logic [2:0] m);
    (sequencer_disable && !listen_enable && mode_field == m) [*4];
  endsequence

  // Calibration restarts, then finishes after its fixed run
  sequence cal_run;
    ##[1:3] !rc_calibration_done ##[250:262] rc_calibration_done;
  endsequence

  a_direct_sleep: assert property (direct_hold(3'h0) |->
    !synth_on && !receiver_on && active_mode == 3'h0) else $error("sleep not dark");
  a_direct_synth: assert property (direct_hold(3'h2) |->
    synth_on && !receiver_on && active_mode == 3'h2) else $error("synth mode wrong");
  a_direct_rx: assert property (direct_hold(3'h4) |->
    synth_on && receiver_on && active_mode == 3'h4) else $error("receive mode wrong");
  a_lock_sync: assert property (since_rel > 3 |->
    pll_lock_out == $past(pll_lock_raw, 2)) else $error("lock output wrong");
  a_rx_locked: assert property ($rose(receiver_on) && !sequencer_disable |->
    pll_lock_out && $past(synth_on)) else $error("receiver before lock");
  a_ready_pulse: assert property (receiver_ready_irq |->
    receiver_on ##1 !receiver_ready_irq) else $error("ready pulse wrong");
  a_nosync_data: assert property (receiver_ready_irq && !bit_sync_enable |->
    ##[0:2] data_valid) else $error("data late");
  a_sync_wait: assert property ($rose(data_valid) && bit_sync_enable |->
    since_rdy >= 12 * bit_period_cycles - 1) else $error("data before preamble");
  a_timeout_gate: assert property (timeout_irq |->
    $past(rx_start_timeout_count) != 8'h00 ##1 !timeout_irq) else $error("bad timeout");
  a_flush_pulse: assert property (buffer_flush |->
    $past(listen_enable) ##1 !buffer_flush) else $error("bad flush");
  a_cal_run: assert property ($rose(rc_calibration_start) |-> cal_run)
    else $error("calibration run wrong");
  a_stop_clears: assert property (!listen_enable [*2] |-> !listen_stopped)
    else $error("stop flag stuck");
endmodule

bind receiver_mode_sequencer receiver_mode_sequencer_chk i_receiver_mode_sequencer_chk
(
  .clk, .arst_n, .mode_field, .listen_enable, .sequencer_disable, .bit_sync_enable,
  .bit_period_cycles, .pll_lock_raw, .rx_start_timeout_count, .rc_calibration_start,
  .active_mode, .synth_on, .receiver_on, .pll_lock_out, .receiver_ready_irq, .data_valid,
  .timeout_irq, .buffer_flush, .rc_calibration_done, .listen_stopped
);

//--- sim/test_receiver_mode_sequencer.sv
`timescale 1ns/1ps
`include "rms_cfg.svh"
module test_receiver_mode_sequencer;
  logic                    clk, arst_n, listen_enable, sequencer_disable, ook_mode;
  logic                    bit_sync_enable, rssi_raw, sync_word_hit, payload_complete_irq;
  logic                    listen_accept_rule, rc_calibration_start, auto_enter_trigger;
  logic                    auto_exit_trigger, pll_lock_raw, crystal_on, synth_on, receiver_on;
  logic                    pll_lock_out, receiver_ready_irq, data_valid, signal_level_threshold;
  logic                    timeout_irq, buffer_flush, rc_calibration_done, listen_stopped;
  logic [2:0]              mode_field, active_mode;
  logic [1:0]              listen_end_action;
  logic [7:0]              rx_start_timeout_count;
  logic [15:0]             bit_period_cycles, receive_bandwidth_cycles;
  logic [15:0]             crystal_wake_time, synth_wake_time;
  rms_pkg::listen_window_t rx_window, idle_window;
  rms_pkg::auto_cfg_t      auto_cfg;
  logic [2:0]              codes [5] = '{3'h4, 3'h0, 3'h3, 3'h2, 3'h1};
  int                      num_errors, cmp_count, n, m, lo, b;

  receiver_mode_sequencer i_receiver_mode_sequencer
  (
    .clk, .arst_n, .mode_field, .listen_enable, .sequencer_disable, .ook_mode,
    .bit_sync_enable, .bit_period_cycles, .receive_bandwidth_cycles, .crystal_wake_time,
    .synth_wake_time, .pll_lock_raw, .rssi_raw, .sync_word_hit, .payload_complete_irq,
    .rx_start_timeout_count, .listen_accept_rule, .listen_end_action, .rx_window,
    .idle_window, .rc_calibration_start, .auto_cfg, .auto_enter_trigger, .auto_exit_trigger,
    .active_mode, .crystal_on, .synth_on, .receiver_on, .pll_lock_out, .receiver_ready_irq,
    .data_valid, .signal_level_threshold, .timeout_irq, .buffer_flush, .rc_calibration_done,
    .listen_stopped
  );

  front_end_model i_front_end_model (.clk, .arst_n, .synth_on, .pll_lock_raw);

  // 100 MHz clock
  always #5 clk = ~clk;

  // Reserved codes fall back to sleep
  function automatic logic [2:0] exp_mode(logic [2:0] c);
    return (c == 3'h1 || c == 3'h2 || c == 3'h4) ? c : 3'h0;
  endfunction

  // Synthesizer and receiver enables of a directly entered mode
  function automatic logic [1:0] exp_blocks(logic [2:0] c);
    return {c == 3'h2 || c == 3'h4, c == 3'h4};
  endfunction

  // Shortest receiver start after lock
  function automatic int rx_budget(int bw, int bt, logic ook);
    return `FRONT_END_CYC + (ook ? `CF_OOK_NUM : `CF_FSK_NUM) * bw / 4 + 4 * bt
           + `PLL_RELOCK_CYC + 2 * (bw / 4);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Bounded wait for one of the completion signals; returns edges waited
  task automatic wait_on(input int sel, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'h0;
    while (!hit && cnt < lim)
    begin
      @(posedge clk);
      #1;
      cnt++;
      case (sel)
        0: hit = (receiver_ready_irq === 1'h1);
        1: hit = (timeout_irq === 1'h1);
        2: hit = (buffer_flush === 1'h1);
        3: hit = (receiver_on === 1'h0);
        default: hit = (rc_calibration_done === 1'h1);
      endcase
    end
    if (!hit)
    begin
      num_errors++;
      $display("MISMATCH wait %0d expected event seen none", sel);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, well past the expected run
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    clk = 1'h0;
    arst_n = 1'h0;
    {listen_enable, sequencer_disable, ook_mode, bit_sync_enable, rssi_raw, sync_word_hit,
     payload_complete_irq, listen_accept_rule, rc_calibration_start, auto_enter_trigger,
     auto_exit_trigger, mode_field, listen_end_action, rx_start_timeout_count} = '0;
    {rx_window, idle_window, auto_cfg} = '0;
    {bit_period_cycles, receive_bandwidth_cycles} = {16'h0008, 16'h0010};
    {crystal_wake_time, synth_wake_time} = {16'h0010, 16'h0010};
    void'($urandom(32'h4933));
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    #1;
    check("reset mode", active_mode, 3'h0);
    wait_on(4, 300, n);
    check("power-up cal", n >= 250, 1'h1);
    // Sequenced wake from sleep with random wake times
    @(posedge clk);
    crystal_wake_time <= 16'(10 + $urandom % 40);
    synth_wake_time <= 16'(10 + $urandom % 40);
    bit_period_cycles <= 16'(4 + $urandom % 8);
    receive_bandwidth_cycles <= 16'(8 + $urandom % 16);
    ook_mode <= 1'($urandom % 2);
    rx_start_timeout_count <= 8'h02;
    @(posedge clk);
    mode_field <= 3'h4;
    repeat (3) @(posedge clk);
    #1;
    check("first step", active_mode, 3'h1);
    b = bit_period_cycles;
    lo = crystal_wake_time + synth_wake_time - 4
         + rx_budget(receive_bandwidth_cycles, b, ook_mode);
    wait_on(0, 8000, n);
    check("wake span", n + 3 >= lo && n + 3 <= lo + 80, 1'h1);
    check("lock at ready", pll_lock_out, 1'h1);
    @(posedge clk);
    #1;
    check("data at ready", data_valid, 1'h1);
    wait_on(1, 400, m);
    check("timeout span", m + 1 >= 16 * b - 4 && m + 1 <= 16 * b + 4, 1'h1);
    // Channel hop with bit synchronizer on
    @(posedge clk);
    bit_sync_enable <= 1'h1;
    rx_start_timeout_count <= 8'h00;
    mode_field <= 3'h2;
    repeat (20) @(posedge clk);
    mode_field <= 3'h4;
    wait_on(0, 8000, n);
    repeat (12 * b - 3) @(posedge clk);
    #1;
    check("preamble wait", data_valid, 1'h0);
    // Direct entry of every mode code, plus reserved code 3
    foreach (codes[i])
    begin
      @(posedge clk);
      sequencer_disable <= 1'h1;
      mode_field <= codes[i];
      repeat (4) @(posedge clk);
      #1;
      check("direct mode", active_mode, exp_mode(codes[i]));
      check("direct blocks", {synth_on, receiver_on}, exp_blocks(codes[i]));
    end
    check("standby crystal", crystal_on, 1'h1);
    // Auto-mode: final state rewritten while in the middle state
    @(posedge clk);
    sequencer_disable <= 1'h0;
    mode_field <= 3'h2;
    auto_cfg <= 5'h03;
    repeat (100) @(posedge clk);
    auto_enter_trigger <= 1'h1;
    @(posedge clk);
    auto_enter_trigger <= 1'h0;
    repeat (10) @(posedge clk);
    #1;
    check("middle state", active_mode, 3'h0);
    @(posedge clk);
    mode_field <= 3'h1;
    auto_exit_trigger <= 1'h1;
    @(posedge clk);
    auto_exit_trigger <= 1'h0;
    auto_cfg <= 5'h00;
    repeat (10) @(posedge clk);
    #1;
    check("final state", active_mode, 3'h1);
    // Calibration on request
    @(posedge clk);
    rc_calibration_start <= 1'h1;
    @(posedge clk);
    rc_calibration_start <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    check("cal restart", rc_calibration_done, 1'h0);
    wait_on(4, 300, n);
    // Listen with level but no sync word: receiver must give up
    @(posedge clk);
    rx_window <= 10'h101;
    idle_window <= 10'h101;
    listen_accept_rule <= 1'h1;
    rssi_raw <= 1'h1;
    listen_enable <= 1'h1;
    wait_on(2, 7000, n);
    check("idle span", n >= 6300 && n <= 6410, 1'h1);
    wait_on(0, 6400, n);
    check("level seen", signal_level_threshold, 1'h1);
    wait_on(3, 6500, m);
    check("rx window", n + m <= 6500, 1'h1);
    // Wanted signal under each end action
    for (int a = 0; a < 3; a++)
    begin
      @(posedge clk);
      listen_end_action <= 2'(a);
      listen_accept_rule <= 1'($urandom % 2);
      sync_word_hit <= 1'h1;
      wait_on(2, 14000, n);
      wait_on(0, 6400, n);
      repeat (20) @(posedge clk);
      if (a > 0)
      begin
        payload_complete_irq <= 1'h1;
        @(posedge clk);
        payload_complete_irq <= 1'h0;
        repeat (10) @(posedge clk);
      end
      #1;
      check("rx kept", receiver_on, 1'(a == 0));
      check("listen stop", listen_stopped, 1'(a < 2));
      if (a == 1)
        check("back to mode", active_mode, 3'h1);
      if (a == 2)
        wait_on(2, 7000, n);
      @(posedge clk);
      listen_enable <= 1'h0;
      repeat (10) @(posedge clk);
      #1;
      check("stop cleared", listen_stopped, 1'h0);
      check("left listen", active_mode, 3'h1);
      @(posedge clk);
      listen_enable <= 1'h1;
    end
    report_and_stop();
  end
endmodule
